/* src/elc_pkg.sv */
// Package for the external line event controller: register map, reset values, field masks, carrier types.
// Assumes a 32-bit register port and a single 25 MHz core clock.
package elc_pkg;
  localparam int unsigned ELC_LINES = 32;
  localparam int unsigned ELC_AW = 5;
  localparam logic [4:0] ELC_OFS_IMASK = 5'h00;
  localparam logic [4:0] ELC_OFS_EMASK = 5'h04;
  localparam logic [4:0] ELC_OFS_RISE = 5'h08;
  localparam logic [4:0] ELC_OFS_FALL = 5'h0c;
  localparam logic [4:0] ELC_OFS_SWTRIG = 5'h10;
  localparam logic [4:0] ELC_OFS_PEND = 5'h14;
  localparam logic [4:0] ELC_OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0] ELC_OFS_IRQ_MASK = 5'h1c;
  localparam logic [31:0] ELC_RST_IMASK = 32'h7f840000;
  localparam logic [31:0] ELC_RST_EMASK = 32'h00000000;
  localparam logic [31:0] ELC_RST_RISE = 32'h00000000;
  localparam logic [31:0] ELC_RST_FALL = 32'h00000000;
  localparam logic [31:0] ELC_RST_SWTRIG = 32'h00000000;
  localparam logic [31:0] ELC_RST_PEND = 32'h00000000;
  localparam logic [31:0] ELC_RST_STAT = 32'h00000000;
  // Lines 17:0, 22:19 and 31 exist; 18 and 30:23 are reserved
  localparam logic [31:0] ELC_IMPL_MASK = 32'h807bffff;
  // Status bit positions of the block's own summary interrupt
  localparam int unsigned ELC_ST_PEND = 0;
  localparam int unsigned ELC_ST_EVT = 1;
  localparam int unsigned ELC_ST_W = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [31:0] wdata;
  } elc_bus_req_t;

  typedef struct packed {
    logic [31:0] irq;
    logic [31:0] evt;
  } elc_out_t;
endpackage

/* src/elc_sync.sv */
// Two-flop synchroniser for the line inputs.
// Assumes inputs are already glitch free at their source.
`timescale 1ns/1ps
`default_nettype none
module elc_sync #(
  parameter int unsigned W = 32
) (
  input wire logic core_clk, // Core clock
  input wire logic rstn, // Async reset, low
  input wire logic [W-1:0] din, // Raw lines
  output logic [W-1:0] dout // Synchronised lines
);
  logic [W-1:0] meta;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

/* src/elc_edge.sv */
// Edge detector over synchronised lines, one trigger per qualifying transition.
// Assumes its input comes from the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module elc_edge #(
  parameter int unsigned W = 32
) (
  input wire logic core_clk, // Core clock
  input wire logic rstn, // Async reset, low
  input wire logic [W-1:0] din, // Synchronised lines
  output logic [W-1:0] rise, // Rising seen, comb
  output logic [W-1:0] fall // Falling seen, comb
);
  logic [W-1:0] prev;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev <= '0;
    end else begin
      prev <= din;
    end
  end
  assign rise = din & ~prev;
  assign fall = ~din & prev;
endmodule
`default_nettype wire

/* src/elc_top.sv */
// External line event controller: 23 of 32 lines implemented, edge triggers, masks, software trigger, pending flags.
// Assumes a plain register port, read data one cycle after the strobe, one 25 MHz clock.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module elc_top
  import elc_pkg::*;
#(
  parameter int unsigned LINES = 32
) (
  input wire logic core_clk, // 25 MHz core clock
  input wire logic rstn, // Async reset, low
  input wire logic [LINES-1:0] line_in, // External lines
  input wire elc_pkg::elc_bus_req_t bus_req, // Register request
  output logic [31:0] rdata, // Read data, cycle after read
  output elc_pkg::elc_out_t line_out, // Per-line irq and event pulses
  output logic irq // Summary interrupt level
);
  import elc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [LINES-1:0] line_sync;
  logic [LINES-1:0] rise_seen;
  logic [LINES-1:0] fall_seen;
  logic [31:0] line_irq_open;
  logic [31:0] line_evt_open;
  logic [31:0] rise_detect_on;
  logic [31:0] fall_detect_on;
  logic [31:0] soft_line_trigger;
  logic [31:0] line_pending_flag;
  logic [ELC_ST_W-1:0] irq_stat;
  logic [ELC_ST_W-1:0] irq_mask;
  logic [31:0] hw_trig;
  logic [31:0] hw_pend;
  logic [31:0] sw_set;
  logic [31:0] pend_clr;
  logic [31:0] polarity_chg;
  logic [31:0] wd;
  logic edge_wr;
  logic wr_imask, wr_emask, wr_rise, wr_fall, wr_sw, wr_pend, wr_stat, wr_smask;

  elc_sync #(.W(LINES)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(line_in),
    .dout(line_sync)
  );

  elc_edge #(.W(LINES)) u_edge (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(line_sync),
    .rise(rise_seen),
    .fall(fall_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wd = bus_req.wdata;
  assign wr_imask = bus_req.wr && (bus_req.addr == ELC_OFS_IMASK);
  assign wr_emask = bus_req.wr && (bus_req.addr == ELC_OFS_EMASK);
  assign wr_rise = bus_req.wr && (bus_req.addr == ELC_OFS_RISE);
  assign wr_fall = bus_req.wr && (bus_req.addr == ELC_OFS_FALL);
  assign wr_sw = bus_req.wr && (bus_req.addr == ELC_OFS_SWTRIG);
  assign wr_pend = bus_req.wr && (bus_req.addr == ELC_OFS_PEND);
  assign wr_stat = bus_req.wr && (bus_req.addr == ELC_OFS_IRQ_STAT);
  assign wr_smask = bus_req.wr && (bus_req.addr == ELC_OFS_IRQ_MASK);
  assign edge_wr = wr_rise || wr_fall;

  // no trigger while edge select written
  assign hw_trig = edge_wr ? 32'h00000000 :
    (((rise_seen & rise_detect_on) | (fall_seen & fall_detect_on)) & ELC_IMPL_MASK);

  // event-only line stays unpending on an edge; a soft trigger still pends it
  // A line open for events but masked for interrupts only wakes the core
  assign hw_pend = hw_trig & ~(line_evt_open & ~line_irq_open);

  // set only where bit was zero
  assign sw_set = wr_sw ? (wd & ~soft_line_trigger & ELC_IMPL_MASK) : 32'h00000000;

  assign polarity_chg = (wr_rise ? (wd ^ rise_detect_on) : 32'h00000000) |
    (wr_fall ? (wd ^ fall_detect_on) : 32'h00000000);
  assign pend_clr = ((wr_pend ? wd : 32'h00000000) | polarity_chg) & ELC_IMPL_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_irq_open <= ELC_RST_IMASK;
    end else if (wr_imask) begin
      line_irq_open <= wd;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_evt_open <= ELC_RST_EMASK;
    end else if (wr_emask) begin
      line_evt_open <= wd;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rise_detect_on <= ELC_RST_RISE;
    end else if (wr_rise) begin
      rise_detect_on <= wd & ELC_IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fall_detect_on <= ELC_RST_FALL;
    end else if (wr_fall) begin
      fall_detect_on <= wd & ELC_IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_line_trigger <= ELC_RST_SWTRIG;
    end else begin
      soft_line_trigger <= (soft_line_trigger & ~((wr_pend ? wd : 32'h00000000) & ELC_IMPL_MASK)) | sw_set;
    end
  end

  // set by trigger, set wins clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_pending_flag <= ELC_RST_PEND;
    end else begin
      line_pending_flag <= (line_pending_flag & ~pend_clr) | hw_pend | sw_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // irq is pending AND mask
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_out <= '0;
    end else begin
      line_out.irq <= ((line_pending_flag & ~pend_clr) | hw_pend | sw_set) & line_irq_open;
      line_out.evt <= (hw_trig | sw_set) & line_evt_open;
    end
  end

  // Summary status: any new pending bit on an irq-open line, any event pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= ELC_RST_STAT[ELC_ST_W-1:0];
    end else begin
      irq_stat[ELC_ST_PEND] <= (|((hw_trig | sw_set) & line_irq_open)) ||
        (irq_stat[ELC_ST_PEND] && !(wr_stat && wd[ELC_ST_PEND]));
      irq_stat[ELC_ST_EVT] <= (|((hw_trig | sw_set) & line_evt_open)) ||
        (irq_stat[ELC_ST_EVT] && !(wr_stat && wd[ELC_ST_EVT]));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= ELC_RST_STAT[ELC_ST_W-1:0];
    end else if (wr_smask) begin
      irq_mask <= wd[ELC_ST_W-1:0];
    end
  end

  // One cycle behind the status bits, registered output
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ELC_OFS_IMASK: rdata <= line_irq_open;
        ELC_OFS_EMASK: rdata <= line_evt_open;
        ELC_OFS_RISE: rdata <= rise_detect_on;
        ELC_OFS_FALL: rdata <= fall_detect_on;
        ELC_OFS_SWTRIG: rdata <= soft_line_trigger;
        ELC_OFS_PEND: rdata <= line_pending_flag;
        ELC_OFS_IRQ_STAT: rdata <= {{(32-ELC_ST_W){1'b0}}, irq_stat};
        ELC_OFS_IRQ_MASK: rdata <= {{(32-ELC_ST_W){1'b0}}, irq_mask};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* verification/elc_top_checker.sv */
// Port checker for elc_top.
// Assumes it is bound to elc_top; it keeps shadows of the mask writes.
`timescale 1ns/1ps
`default_nettype none
module elc_top_checker
  import elc_pkg::*;
#(
  parameter int unsigned LINES = 32
) (
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic [LINES-1:0] line_in, // Lines
  input wire elc_pkg::elc_bus_req_t bus_req, // Request
  input wire logic [31:0] rdata, // Read data
  input wire elc_pkg::elc_out_t line_out, // Irq, events
  input wire logic irq // Summary
);
  logic [31:0] im;
  logic [31:0] em;
  logic [31:0] sw;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////
  // Soft bits are shadowed so a repeated write is not taken as a trigger
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      im <= ELC_RST_IMASK;
      em <= 32'h0;
      sw <= 32'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ELC_OFS_IMASK) im <= bus_req.wdata;
      if (bus_req.addr == ELC_OFS_EMASK) em <= bus_req.wdata;
      if (bus_req.addr == ELC_OFS_SWTRIG) sw <= sw | (bus_req.wdata & ELC_IMPL_MASK);
      if (bus_req.addr == ELC_OFS_PEND) sw <= sw & ~bus_req.wdata;
    end
  end
  ////////////////////
  a_imask_read: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ELC_OFS_IMASK |-> rdata == $past(im)) else $error("mask readback");
  a_emask_read: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ELC_OFS_EMASK |-> rdata == $past(em)) else $error("evt readback");
  a_irq_gate: assert property ((line_out.irq & ~im & ~$past(im)) == '0)
    else $error("irq through closed mask");
  a_evt_blocked: assert property (em == '0 && $past(em) == '0 |-> line_out.evt == '0)
    else $error("event through closed mask");
  a_evt_single: assert property ((line_out.evt & $past(line_out.evt)) == '0)
    else $error("event longer than one cycle");
  a_soft_evt: assert property (bus_req.wr && bus_req.addr == ELC_OFS_SWTRIG
    && (bus_req.wdata & ~sw & em & ELC_IMPL_MASK) != '0 |-> ##[1:2] line_out.evt != '0) else $error("no soft event");
  a_irq_hold: assert property (($past(line_out.irq) & ~line_out.irq) != '0
    |-> $past(bus_req.wr) || $past(bus_req.wr, 2)) else $error("irq dropped unasked");
  a_reserved_quiet: assert property (((line_out.irq | line_out.evt) & ~ELC_IMPL_MASK) == '0)
    else $error("reserved line active");
endmodule
bind elc_top elc_top_checker #(.LINES(LINES)) u_chk (.core_clk, .rstn, .line_in, .bus_req, .rdata, .line_out, .irq);
`default_nettype wire

/* verification/elc_core_model.sv */
// Core-side model: counts the event pulses that reach the wake-up logic.
// Assumes event pulses last one core clock.
`timescale 1ns/1ps
`default_nettype none
module elc_core_model
  import elc_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset, low
  input wire elc_pkg::elc_out_t line_out, // Irq and events
  output logic [7:0] evt_count // Pulses seen
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) evt_count <= 8'h0;
    else if (line_out.evt != '0) evt_count <= evt_count + 8'h1;
  end
endmodule
`default_nettype wire

/* verification/elc_top_bench.sv */
// Bench for elc_top: registers, edges, soft trigger, summary interrupt.
// Assumes the core-side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module elc_top_bench;
  import elc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] lines = 32'h0;
  elc_bus_req_t req = '0;
  logic [31:0] rdata;
  elc_out_t lo;
  logic irq;
  logic [7:0] evts;
  int errors = 0;
  int checks_done = 0;
  always #20 core_clk = ~core_clk;
  elc_top DUT (.core_clk, .rstn, .line_in(lines), .bus_req(req), .rdata, .line_out(lo), .irq);
  elc_core_model u_core (.core_clk, .rstn, .line_out(lo), .evt_count(evts));
  ////////////////////
  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Index 32 stands for the summary output; bounded so a stuck level ends the run
  task automatic wait_irq(input int i, input logic v);
    // Look after the edge has settled, never in the edge's own time step
    #1;
    for (int n = 0; n < 12 && (i == 32 ? irq : lo.irq[i]) !== v; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk({31'h0, (i == 32 ? irq : lo.irq[i])}, {31'h0, v});
    if ((i == 32 ? irq : lo.irq[i]) !== v) end_of_test();
  endtask
  ////////////////////
  task automatic t_regs();
    rchk(ELC_OFS_IMASK, 32'h7f840000);
    rchk(5'h02, 32'h0);
    wr(ELC_OFS_RISE, 32'hffffffff);
    rchk(ELC_OFS_RISE, 32'h807bffff);
    wr(ELC_OFS_FALL, 32'hffffffff);
    rchk(ELC_OFS_FALL, 32'h807bffff);
    wr(ELC_OFS_SWTRIG, 32'h00040000);
    rchk(ELC_OFS_SWTRIG, 32'h0);
    wr(ELC_OFS_RISE, 32'h1);
    wr(ELC_OFS_FALL, 32'h0);
  endtask
  task automatic t_edge();
    lines[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    rchk(ELC_OFS_PEND, 32'h1);
    chk({31'h0, lo.irq[0]}, 32'h0);
    wr(ELC_OFS_IMASK, 32'h1);
    wait_irq(0, 1'b1);
    wr(ELC_OFS_PEND, 32'h1);
    wait_irq(0, 1'b0);
    wr(ELC_OFS_EMASK, 32'h1);
    wr(ELC_OFS_FALL, 32'h1);
    lines[0] <= 1'b0;
    wait_irq(0, 1'b1);
    rchk(ELC_OFS_PEND, 32'h1);
    chk({24'h0, evts}, 32'h1);
    wr(ELC_OFS_FALL, 32'h0);
    wait_irq(0, 1'b0);
  endtask
  // Line change lands so its edge is seen in the cycle the select write is taken
  task automatic t_block();
    @(posedge core_clk);
    lines[0] <= 1'b1;
    repeat (1) @(posedge core_clk);
    wr(ELC_OFS_RISE, 32'h1);
    repeat (4) @(posedge core_clk);
    rchk(ELC_OFS_PEND, 32'h0);
  endtask
  task automatic t_soft();
    wr(ELC_OFS_EMASK, 32'h2);
    wr(ELC_OFS_IMASK, 32'h2);
    wr(ELC_OFS_IRQ_STAT, 32'h3);
    wr(ELC_OFS_IRQ_MASK, 32'h2);
    wr(ELC_OFS_SWTRIG, 32'h2);
    wait_irq(1, 1'b1);
    rchk(ELC_OFS_SWTRIG, 32'h2);
    rchk(ELC_OFS_PEND, 32'h2);
    wait_irq(32, 1'b1);
    wr(ELC_OFS_SWTRIG, 32'h2);
    wr(ELC_OFS_SWTRIG, 32'h0);
    chk({24'h0, evts}, 32'h2);
    rchk(ELC_OFS_IRQ_STAT, 32'h3);
    wr(ELC_OFS_IRQ_MASK, 32'h0);
    wait_irq(32, 1'b0);
    wr(ELC_OFS_IRQ_STAT, 32'h3);
    rchk(ELC_OFS_IRQ_STAT, 32'h0);
    wr(ELC_OFS_PEND, 32'h2);
    rchk(ELC_OFS_SWTRIG, 32'h0);
    wait_irq(1, 1'b0);
  endtask
  // Event-only line: one pulse reaches the core, nothing pends
  task automatic t_evt();
    wr(ELC_OFS_EMASK, 32'h4);
    wr(ELC_OFS_RISE, 32'h5);
    lines[2] <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk({24'h0, evts}, 32'h3);
    rchk(ELC_OFS_PEND, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_edge();
    t_block();
    t_soft();
    t_evt();
    end_of_test();
  end
endmodule
`default_nettype wire
